// [shared/mqf_pkg.sv]
`default_nettype none
package mqf_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_QUEUES = 16;
  localparam int QSEL_W = 4;
  localparam int WORD_W = 36;
  localparam int BLOCK_SHIFT = 8;               // 256 words per block
  localparam int BLOCK_WORDS = 256;
  localparam int DENSITY_BLOCKS = 64;           // Density options: 64, 128 or 256
  localparam int BLK_W = 9;                     // Holds 0..256 blocks
  localparam int ADDR_W = 16;                   // Word offset within a queue
  localparam int CNT_W = 17;                    // Word count, up to 65536
  localparam int MEM_WORDS = DENSITY_BLOCKS * BLOCK_WORDS;
  localparam int MEM_AW = $clog2(MEM_WORDS);
  localparam int LANE_W = 2;

  // ----------------------------------------------------------------
  // Reset configuration: all queues, equal share of the pool
  // ----------------------------------------------------------------
  localparam logic [QSEL_W:0] DEF_NUM_Q = 5'h10;
  localparam logic [BLK_W-1:0] DEF_BLOCKS = 9'h004;
  localparam logic [CNT_W-1:0] DEF_FLAG_OFF = 17'h00008;

  // Port width choice, global to all queues
  typedef enum logic [1:0] {
    MQF_W36 = 2'b00,
    MQF_W18 = 2'b01,
    MQF_W9 = 2'b10
  } mqf_width_t;

  // Index of the last narrow lane of a 36-bit word
  function automatic logic [LANE_W-1:0] mqf_last_lane(mqf_width_t w);
    case (w)
      MQF_W18: mqf_last_lane = 2'h1;
      MQF_W9: mqf_last_lane = 2'h3;
      default: mqf_last_lane = 2'h0;
    endcase
  endfunction

  // Bit count of one lane
  function automatic logic [5:0] mqf_lane_bits(mqf_width_t w);
    case (w)
      MQF_W18: mqf_lane_bits = 6'h12;
      MQF_W9: mqf_lane_bits = 6'h09;
      default: mqf_lane_bits = 6'h24;
    endcase
  endfunction
endpackage
`default_nettype wire

// [shared/mqf_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface mqf_if;
  // ----------------------------------------------------------------
  // Write port, read port, configuration, flags
  // ----------------------------------------------------------------
  logic wr_en;
  logic [mqf_pkg::QSEL_W-1:0] write_queue_select;
  logic [mqf_pkg::WORD_W-1:0] wr_data;
  logic rd_en;
  logic [mqf_pkg::QSEL_W-1:0] read_queue_select;
  logic [mqf_pkg::WORD_W-1:0] rd_data;
  logic full_flag_n;
  logic almost_full_flag_n;
  logic output_valid_n;
  logic almost_empty_flag_n;
  logic cfg_we;
  logic [mqf_pkg::QSEL_W-1:0] cfg_queue;
  logic [mqf_pkg::BLK_W-1:0] cfg_base;
  logic [mqf_pkg::BLK_W-1:0] cfg_blocks;
  logic [mqf_pkg::CNT_W-1:0] cfg_af;
  logic [mqf_pkg::CNT_W-1:0] cfg_ae;
  logic cfg_glb_we;
  logic [mqf_pkg::QSEL_W:0] cfg_num_q;
  mqf_pkg::mqf_width_t cfg_in_w;
  mqf_pkg::mqf_width_t cfg_out_w;

  modport device (
    input wr_en, write_queue_select, wr_data, rd_en, read_queue_select,
    input cfg_we, cfg_queue, cfg_base, cfg_blocks, cfg_af, cfg_ae,
    input cfg_glb_we, cfg_num_q, cfg_in_w, cfg_out_w,
    output rd_data, full_flag_n, almost_full_flag_n, output_valid_n, almost_empty_flag_n
  );
  modport host (
    output wr_en, write_queue_select, wr_data, rd_en, read_queue_select,
    output cfg_we, cfg_queue, cfg_base, cfg_blocks, cfg_af, cfg_ae,
    output cfg_glb_we, cfg_num_q, cfg_in_w, cfg_out_w,
    input rd_data, full_flag_n, almost_full_flag_n, output_valid_n, almost_empty_flag_n
  );
endinterface
`default_nettype wire

// [core/mqf_device.sv]
// The implementer's own choices: the setup strobes and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module mqf_device (
  input wire logic i_clk,          // System clock, 20 MHz
  input wire logic i_reset_n,      // Asynchronous reset, active low
  mqf_if.device bus                // Link to the writer/reader end
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::ADDR_W-1:0] wr_ptr;
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::ADDR_W-1:0] rd_ptr;
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::CNT_W-1:0] count;
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::BLK_W-1:0] base;
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::BLK_W-1:0] size;
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::CNT_W-1:0] af_off;
    logic [mqf_pkg::NUM_QUEUES-1:0][mqf_pkg::CNT_W-1:0] ae_off;
    logic [mqf_pkg::QSEL_W:0] num_q;
    mqf_pkg::mqf_width_t in_w;
    mqf_pkg::mqf_width_t out_w;
    logic [mqf_pkg::WORD_W-1:0] pack;
    logic [mqf_pkg::LANE_W-1:0] wr_lane;
    logic [mqf_pkg::LANE_W-1:0] rd_lane;
    logic [mqf_pkg::QSEL_W-1:0] rd_sel;
    logic [mqf_pkg::WORD_W-1:0] out_data;
    logic ov_n;
    logic full_n;
    logic af_n;
    logic ae_n;
  } mqf_dev_state_t;

  mqf_dev_state_t s;
  mqf_dev_state_t next_s;
  logic [mqf_pkg::WORD_W-1:0] mem [0:mqf_pkg::MEM_WORDS-1];
  logic mem_we;
  logic [mqf_pkg::MEM_AW-1:0] mem_waddr;
  logic [mqf_pkg::WORD_W-1:0] mem_wdata;

  // Reset state: default equal split of the pool over all queues
  function automatic mqf_dev_state_t reset_state();
    mqf_dev_state_t r;
    r = '0;
    r.num_q = mqf_pkg::DEF_NUM_Q;
    r.in_w = mqf_pkg::MQF_W36;
    r.out_w = mqf_pkg::MQF_W36;
    r.ov_n = 1'b1;
    r.full_n = 1'b1;
    r.af_n = 1'b1;
    for (int q = 0; q < mqf_pkg::NUM_QUEUES; q++) begin
      r.base[q] = mqf_pkg::BLK_W'(q) * mqf_pkg::DEF_BLOCKS;
      r.size[q] = mqf_pkg::DEF_BLOCKS;
      r.af_off[q] = mqf_pkg::DEF_FLAG_OFF;
      r.ae_off[q] = mqf_pkg::DEF_FLAG_OFF;
    end
    return r;
  endfunction

  // Queue depth in words, always a whole number of blocks
  function automatic logic [mqf_pkg::CNT_W-1:0] words(logic [mqf_pkg::BLK_W-1:0] b);
    return {b, mqf_pkg::BLOCK_SHIFT'(0)};
  endfunction

  // Physical address of an offset inside a queue
  function automatic logic [mqf_pkg::MEM_AW-1:0] phys(logic [mqf_pkg::BLK_W-1:0] b,
                                                      logic [mqf_pkg::ADDR_W-1:0] p);
    logic [mqf_pkg::CNT_W:0] a;
    a = {1'b0, b, mqf_pkg::BLOCK_SHIFT'(0)} + {2'b00, p};
    return a[mqf_pkg::MEM_AW-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Both ports are evaluated in the same pass so a push and a pop on
  // one queue in one cycle net out in its count.
  always_comb begin
    logic [mqf_pkg::QSEL_W-1:0] wq;
    logic [mqf_pkg::QSEL_W-1:0] rq;
    logic wq_ok;
    logic rq_ok;
    logic push;
    logic pop;
    logic [5:0] sh;
    logic [mqf_pkg::WORD_W-1:0] mask;
    logic [mqf_pkg::WORD_W-1:0] head;
    logic [mqf_pkg::MEM_AW-1:0] raddr;
    logic [mqf_pkg::ADDR_W-1:0] np;
    next_s = s;
    wq = bus.write_queue_select;
    rq = bus.read_queue_select;
    wq_ok = {1'b0, wq} < s.num_q;
    rq_ok = {1'b0, rq} < s.num_q;
    push = 1'b0;
    pop = 1'b0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    head = '0;
    raddr = '0;
    np = '0;
    // Write side: lanes gather into one word, stored on the last lane
    sh = 6'(s.wr_lane * mqf_pkg::mqf_lane_bits(s.in_w));
    mask = ~(36'hF_FFFF_FFFF << mqf_pkg::mqf_lane_bits(s.in_w));
    if (bus.wr_en && wq_ok && (s.count[wq] < words(s.size[wq]))) begin
      next_s.pack = (s.pack & ~(mask << sh)) | ((bus.wr_data & mask) << sh);
      if (s.wr_lane == mqf_pkg::mqf_last_lane(s.in_w)) begin
        push = 1'b1;
        next_s.wr_lane = '0;
        mem_we = 1'b1;
        mem_waddr = phys(s.base[wq], s.wr_ptr[wq]);
        mem_wdata = next_s.pack;
        np = s.wr_ptr[wq] + 16'h0001;
        next_s.wr_ptr[wq] = ({1'b0, np} == words(s.size[wq])) ? '0 : np;
      end else begin
        next_s.wr_lane = s.wr_lane + 2'h1;
      end
    end
    // Read side: the shown word is consumed lane by lane
    if (rq != s.rd_sel) begin
      next_s.rd_lane = '0;
    end else if (bus.rd_en && !s.ov_n) begin
      if (s.rd_lane == mqf_pkg::mqf_last_lane(s.out_w)) begin
        pop = 1'b1;
        next_s.rd_lane = '0;
        np = s.rd_ptr[rq] + 16'h0001;
        next_s.rd_ptr[rq] = ({1'b0, np} == words(s.size[rq])) ? '0 : np;
      end else begin
        next_s.rd_lane = s.rd_lane + 2'h1;
      end
    end
    // Independent ports on the same queue still keep the count exact
    if (push && pop && wq == rq) begin
      next_s.count[wq] = s.count[wq];
    end else begin
      if (push) begin
        next_s.count[wq] = s.count[wq] + 17'h00001;
      end
      if (pop) begin
        next_s.count[rq] = s.count[rq] - 17'h00001;
      end
    end
    // Head of the selected queue falls through to the output register
    next_s.rd_sel = rq;
    if (rq_ok && next_s.count[rq] != '0) begin
      raddr = phys(s.base[rq], next_s.rd_ptr[rq]);
      // A word written this cycle is not in the array yet
      head = (mem_we && mem_waddr == raddr) ? mem_wdata : mem[raddr];
      sh = 6'(next_s.rd_lane * mqf_pkg::mqf_lane_bits(s.out_w));
      mask = ~(36'hF_FFFF_FFFF << mqf_pkg::mqf_lane_bits(s.out_w));
      next_s.out_data = (head >> sh) & mask;
      next_s.ov_n = 1'b0;
    end else begin
      next_s.ov_n = 1'b1;
    end
    // Configuration, applied last so it wins over traffic
    if (bus.cfg_we) begin
      next_s.base[bus.cfg_queue] = bus.cfg_base;
      next_s.size[bus.cfg_queue] = bus.cfg_blocks;
      next_s.af_off[bus.cfg_queue] = bus.cfg_af;
      next_s.ae_off[bus.cfg_queue] = bus.cfg_ae;
      next_s.wr_ptr[bus.cfg_queue] = '0;
      next_s.rd_ptr[bus.cfg_queue] = '0;
      next_s.count[bus.cfg_queue] = '0;
    end
    if (bus.cfg_glb_we) begin
      next_s.num_q = (bus.cfg_num_q == '0 || bus.cfg_num_q > mqf_pkg::DEF_NUM_Q) ?
                     mqf_pkg::DEF_NUM_Q : bus.cfg_num_q;
      // Both narrow is not allowed; fall back to 36 both ways
      if (bus.cfg_in_w != mqf_pkg::MQF_W36 && bus.cfg_out_w != mqf_pkg::MQF_W36) begin
        next_s.in_w = mqf_pkg::MQF_W36;
        next_s.out_w = mqf_pkg::MQF_W36;
      end else begin
        next_s.in_w = bus.cfg_in_w;
        next_s.out_w = bus.cfg_out_w;
      end
      next_s.wr_lane = '0;
      next_s.rd_lane = '0;
    end
    // Flags of the selected queues, against the updated counts
    next_s.full_n = !(!wq_ok || next_s.count[wq] >= words(next_s.size[wq]));
    next_s.af_n = !(next_s.count[wq] + next_s.af_off[wq] >= words(next_s.size[wq]));
    next_s.ae_n = !(next_s.count[rq] <= next_s.ae_off[rq]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // One clock drives every update; enables, queue selections and setup strobes all shape next_s
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  // Shared pool; contents are undefined after reset, as counts are zero
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Outputs straight from the state register
  assign bus.rd_data = s.out_data;
  assign bus.output_valid_n = s.ov_n;
  assign bus.full_flag_n = s.full_n;
  assign bus.almost_full_flag_n = s.af_n;
  assign bus.almost_empty_flag_n = s.ae_n;
endmodule
`default_nettype wire

// [core/mqf_host.sv]
`timescale 1ns/10ps
`default_nettype none
module mqf_host (
  input wire logic i_clk,                                   // System clock
  input wire logic i_reset_n,                               // Async reset, active low
  mqf_if.host bus,                                          // Link to the queue device
  input wire logic i_wr_valid,                              // Upstream word waiting
  input wire logic [mqf_pkg::QSEL_W-1:0] i_wr_queue,        // Target queue
  input wire logic [mqf_pkg::WORD_W-1:0] i_wr_data,         // Word or lane to write
  output logic o_wr_ready,                                  // Pulse: word taken
  input wire logic i_rd_ready,                              // Downstream can take a word
  input wire logic [mqf_pkg::QSEL_W-1:0] i_rd_queue,        // Source queue
  output logic o_rd_valid,                                  // Pulse: o_rd_data valid
  output logic [mqf_pkg::WORD_W-1:0] o_rd_data,             // Word or lane read
  input wire logic i_cfg_we,                                // Queue setup strobe
  input wire logic [mqf_pkg::QSEL_W-1:0] i_cfg_queue,       // Queue to set up
  input wire logic [mqf_pkg::BLK_W-1:0] i_cfg_base,         // First block
  input wire logic [mqf_pkg::BLK_W-1:0] i_cfg_blocks,       // Block count
  input wire logic [mqf_pkg::CNT_W-1:0] i_cfg_af,           // Almost-full offset
  input wire logic [mqf_pkg::CNT_W-1:0] i_cfg_ae,           // Almost-empty offset
  input wire logic i_cfg_glb_we,                            // Global setup strobe
  input wire logic [mqf_pkg::QSEL_W:0] i_cfg_num_q,         // Queues in use
  input wire mqf_pkg::mqf_width_t i_cfg_in_w,               // Write width
  input wire mqf_pkg::mqf_width_t i_cfg_out_w               // Read width
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic [mqf_pkg::QSEL_W-1:0] wr_sel;
    logic wr_stable;
    logic [mqf_pkg::WORD_W-1:0] wr_data;
    logic rd_en;
    logic [mqf_pkg::QSEL_W-1:0] rd_sel;
    logic rd_stable;
    logic wr_ready;
    logic rd_valid;
    logic [mqf_pkg::WORD_W-1:0] rd_data;
    logic cfg_we;
    logic [mqf_pkg::QSEL_W-1:0] cfg_queue;
    logic [mqf_pkg::BLK_W-1:0] cfg_base;
    logic [mqf_pkg::BLK_W-1:0] cfg_blocks;
    logic [mqf_pkg::CNT_W-1:0] cfg_af;
    logic [mqf_pkg::CNT_W-1:0] cfg_ae;
    logic cfg_glb_we;
    logic [mqf_pkg::QSEL_W:0] cfg_num_q;
    mqf_pkg::mqf_width_t cfg_in_w;
    mqf_pkg::mqf_width_t cfg_out_w;
  } mqf_host_state_t;

  mqf_host_state_t s;
  mqf_host_state_t next_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Device flags lag one cycle, so an enable is only raised when the
  // selection has held a cycle and no enable was issued last cycle.
  // This halves peak rate but never overruns or underruns a queue.
  always_comb begin
    next_s = s;
    next_s.wr_sel = i_wr_queue;
    next_s.wr_stable = (s.wr_sel == i_wr_queue);
    next_s.wr_en = i_wr_valid && s.wr_stable && (s.wr_sel == i_wr_queue) &&
                   !s.wr_en && bus.full_flag_n;
    next_s.wr_data = i_wr_data;
    next_s.wr_ready = next_s.wr_en;
    next_s.rd_sel = i_rd_queue;
    next_s.rd_stable = (s.rd_sel == i_rd_queue);
    next_s.rd_en = i_rd_ready && s.rd_stable && (s.rd_sel == i_rd_queue) &&
                   !s.rd_en && !bus.output_valid_n;
    next_s.rd_valid = next_s.rd_en;
    next_s.rd_data = next_s.rd_en ? bus.rd_data : s.rd_data;
    next_s.cfg_we = i_cfg_we;
    next_s.cfg_queue = i_cfg_queue;
    next_s.cfg_base = i_cfg_base;
    next_s.cfg_blocks = i_cfg_blocks;
    next_s.cfg_af = i_cfg_af;
    next_s.cfg_ae = i_cfg_ae;
    next_s.cfg_glb_we = i_cfg_glb_we;
    next_s.cfg_num_q = i_cfg_num_q;
    next_s.cfg_in_w = i_cfg_in_w;
    next_s.cfg_out_w = i_cfg_out_w;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.wr_en = s.wr_en;
  assign bus.write_queue_select = s.wr_sel;
  assign bus.wr_data = s.wr_data;
  assign bus.rd_en = s.rd_en;
  assign bus.read_queue_select = s.rd_sel;
  assign bus.cfg_we = s.cfg_we;
  assign bus.cfg_queue = s.cfg_queue;
  assign bus.cfg_base = s.cfg_base;
  assign bus.cfg_blocks = s.cfg_blocks;
  assign bus.cfg_af = s.cfg_af;
  assign bus.cfg_ae = s.cfg_ae;
  assign bus.cfg_glb_we = s.cfg_glb_we;
  assign bus.cfg_num_q = s.cfg_num_q;
  assign bus.cfg_in_w = s.cfg_in_w;
  assign bus.cfg_out_w = s.cfg_out_w;
  assign o_wr_ready = s.wr_ready;
  assign o_rd_valid = s.rd_valid;
  assign o_rd_data = s.rd_data;
endmodule
`default_nettype wire

// [bench/mqf_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module mqf_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [mqf_pkg::QSEL_W-1:0] write_queue_select, // Write queue
  input wire logic rd_en, // Read strobe
  input wire logic [mqf_pkg::QSEL_W-1:0] read_queue_select, // Read queue
  input wire logic [mqf_pkg::WORD_W-1:0] rd_data, // Shown word
  input wire logic full_flag_n, // Full, low
  input wire logic almost_full_flag_n, // Almost full, low
  input wire logic output_valid_n, // Valid, low
  input wire logic almost_empty_flag_n, // Almost empty, low
  input wire logic cfg_we, // Queue setup
  input wire logic cfg_glb_we, // Global setup
  input wire logic [mqf_pkg::QSEL_W:0] cfg_num_q // Queue count
);
  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [mqf_pkg::QSEL_W:0] num_q;
  logic no_cfg;
  logic calm;

  // A setup strobe may clear a queue, so it breaks every hold relation
  assign no_cfg = !cfg_we && !cfg_glb_we;
  assign calm = no_cfg && !wr_en && !rd_en;

  // Out-of-range counts fall back to all queues
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      num_q <= mqf_pkg::DEF_NUM_Q;
    end else if (cfg_glb_we) begin
      num_q <= (cfg_num_q == 5'h00 || cfg_num_q > 5'h10) ? 5'h10 : cfg_num_q;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  reset_vals_a:
    assert property ($rose(i_reset_n) |-> output_valid_n && full_flag_n
      && !almost_empty_flag_n && rd_data == 36'h0) else $error("Bad state after reset");
  rd_stall_a:
    assert property (!output_valid_n && !rd_en && no_cfg && $past(no_cfg)
      && $stable(read_queue_select) |=> $stable(rd_data) && !output_valid_n)
      else $error("Word moved without a read");
  ov_hold_a:
    assert property (output_valid_n && $past(output_valid_n) |-> $stable(rd_data))
      else $error("Invalid output word changed");
  full_af_a:
    assert property (!full_flag_n && ({1'h0, $past(write_queue_select)} < $past(num_q))
      |-> !almost_full_flag_n) else $error("Full without almost full");
  wr_idle_a:
    assert property (calm && $past(calm) && $stable(write_queue_select)
      |=> $stable(full_flag_n) && $stable(almost_full_flag_n))
      else $error("Write flags moved while idle");
  rd_idle_a:
    assert property (calm && $past(calm) && $stable(read_queue_select)
      |=> $stable(output_valid_n) && $stable(almost_empty_flag_n) && $stable(rd_data))
      else $error("Read side moved while idle");
  bad_wsel_a:
    assert property (({1'h0, write_queue_select} >= num_q) && no_cfg |=> !full_flag_n)
      else $error("Unused write queue not full");
  bad_rsel_a:
    assert property (({1'h0, read_queue_select} >= num_q) && no_cfg |=> output_valid_n)
      else $error("Unused read queue shows data");

  cov_full: cover property ($fell(full_flag_n));
  cov_read: cover property (rd_en && !output_valid_n);
  cov_glb: cover property (cfg_glb_we);
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Clock, reset and user-side stimulus
  // ----------------------------------------------------------------
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic wr_valid = 1'h0;
  logic [3:0] wr_queue = 4'h0;
  logic [35:0] wr_word = 36'h0;
  logic wr_ready;
  logic rd_ready = 1'h0;
  logic [3:0] rd_queue = 4'h0;
  logic rd_valid;
  logic [35:0] rd_word;
  logic cfg_we = 1'h0;
  logic [3:0] cfg_queue = 4'h0;
  logic [8:0] cfg_blocks = 9'h004;
  logic [16:0] cfg_ae = 17'h00008;
  logic cfg_glb_we = 1'h0;
  logic [4:0] cfg_num_q = 5'h10;
  mqf_pkg::mqf_width_t cfg_in_w = mqf_pkg::MQF_W36;
  mqf_pkg::mqf_width_t cfg_out_w = mqf_pkg::MQF_W36;
  mqf_pkg::mqf_width_t wi_tab [4] = '{mqf_pkg::MQF_W9, mqf_pkg::MQF_W18,
    mqf_pkg::MQF_W36, mqf_pkg::MQF_W36};
  mqf_pkg::mqf_width_t wo_tab [4] = '{mqf_pkg::MQF_W36, mqf_pkg::MQF_W36,
    mqf_pkg::MQF_W18, mqf_pkg::MQF_W9};
  int num_errors = 0;
  int checks_done = 0;

  // 20 MHz
  always #25 i_clk = ~i_clk;

  mqf_if bus ();
  mqf_device mqf_device_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus));
  // Base and almost-full offset are fixed: queue 1 keeps to its own default blocks
  mqf_host mqf_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
    .i_wr_valid(wr_valid), .i_wr_queue(wr_queue), .i_wr_data(wr_word),
    .o_wr_ready(wr_ready), .i_rd_ready(rd_ready), .i_rd_queue(rd_queue),
    .o_rd_valid(rd_valid), .o_rd_data(rd_word), .i_cfg_we(cfg_we),
    .i_cfg_queue(cfg_queue), .i_cfg_base(9'h004), .i_cfg_blocks(cfg_blocks),
    .i_cfg_af(17'h00010), .i_cfg_ae(cfg_ae), .i_cfg_glb_we(cfg_glb_we),
    .i_cfg_num_q(cfg_num_q), .i_cfg_in_w(cfg_in_w), .i_cfg_out_w(cfg_out_w));
  mqf_assertions mqf_assertions_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .wr_en(bus.wr_en), .write_queue_select(bus.write_queue_select), .rd_en(bus.rd_en),
    .read_queue_select(bus.read_queue_select), .rd_data(bus.rd_data),
    .full_flag_n(bus.full_flag_n), .almost_full_flag_n(bus.almost_full_flag_n),
    .output_valid_n(bus.output_valid_n), .almost_empty_flag_n(bus.almost_empty_flag_n),
    .cfg_we(bus.cfg_we), .cfg_glb_we(bus.cfg_glb_we), .cfg_num_q(bus.cfg_num_q));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp);
    check({35'h0, seen}, {35'h0, exp});
  endtask

  // Flags change on the storing edge itself; wait three cycles to be sure
  task automatic settle;
    repeat (3) @(negedge i_clk);
  endtask

  // Valid is held until taken; a full queue gives up after 40 cycles
  task automatic push(input logic [3:0] q, input logic [35:0] d, output logic took);
    int n;
    n = 0;
    @(posedge i_clk);
    wr_queue <= q;
    wr_word <= d;
    wr_valid <= 1'h1;
    do begin
      @(negedge i_clk);
      n++;
    end while (wr_ready !== 1'h1 && n < 40);
    took = (wr_ready === 1'h1);
    @(posedge i_clk);
    wr_valid <= 1'h0;
  endtask

  task automatic pop(input logic [3:0] q, output logic [35:0] d);
    int n;
    logic ok;
    n = 0;
    @(posedge i_clk);
    rd_queue <= q;
    rd_ready <= 1'h1;
    do begin
      @(negedge i_clk);
      n++;
    end while (rd_valid !== 1'h1 && n < 40);
    ok = (rd_valid === 1'h1);
    @(posedge i_clk);
    rd_ready <= 1'h0;
    @(negedge i_clk);
    d = ok ? rd_word : 36'hX;
  endtask

  task automatic set_glb(input logic [4:0] n, input mqf_pkg::mqf_width_t wi,
    input mqf_pkg::mqf_width_t wo);
    @(posedge i_clk);
    cfg_num_q <= n;
    cfg_in_w <= wi;
    cfg_out_w <= wo;
    cfg_glb_we <= 1'h1;
    @(posedge i_clk);
    cfg_glb_we <= 1'h0;
    repeat (3) @(posedge i_clk);
  endtask

  function automatic int lane_w(input mqf_pkg::mqf_width_t w);
    return (w == mqf_pkg::MQF_W9) ? 9 : (w == mqf_pkg::MQF_W18) ? 18 : 36;
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic took;
    logic [35:0] got;
    int bi;
    int bo;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'h1;
    settle();
    flag(bus.output_valid_n, 1'h1);
    flag(bus.almost_empty_flag_n, 1'h0);
    // Interleaved writes to two queues must come back apart and in order
    for (int k = 0; k < 3; k++) begin
      push(4'h2, 36'hA00000000 + 36'(k), took);
      push(4'h5, 36'hB00000000 + 36'(k), took);
    end
    for (int k = 0; k < 3; k++) begin
      pop(4'h5, got);
      check(got, 36'hB00000000 + 36'(k));
    end
    for (int k = 0; k < 3; k++) begin
      pop(4'h2, got);
      check(got, 36'hA00000000 + 36'(k));
    end
    // Head shows on selection alone, and stays when moving to an empty queue
    push(4'h3, 36'hC12345678, took);
    @(posedge i_clk);
    rd_queue <= 4'h3;
    settle();
    check(bus.rd_data, 36'hC12345678);
    flag(bus.output_valid_n, 1'h0);
    @(posedge i_clk);
    rd_queue <= 4'h7;
    settle();
    check(bus.rd_data, 36'hC12345678);
    flag(bus.output_valid_n, 1'h1);
    // Writer and reader on one queue at once
    fork
      for (int k = 0; k < 4; k++) push(4'h4, 36'hD0 + 36'(k), took);
      for (int k = 0; k < 4; k++) begin
        pop(4'h4, got);
        check(got, 36'hD0 + 36'(k));
      end
    join
    // Every width pair with one narrow port, lanes in little-endian order
    for (int t = 0; t < 4; t++) begin
      set_glb(5'h10, wi_tab[t], wo_tab[t]);
      bi = lane_w(wi_tab[t]);
      bo = lane_w(wo_tab[t]);
      for (int k = 0; k < 36 / bi; k++) begin
        push(4'h8, (36'h987654321 >> (k * bi)) & ((36'h1 << bi) - 36'h1), took);
      end
      for (int k = 0; k < 36 / bo; k++) begin
        pop(4'h8, got);
        check(got, (36'h987654321 >> (k * bo)) & ((36'h1 << bo) - 36'h1));
      end
    end
    set_glb(5'h10, mqf_pkg::MQF_W36, mqf_pkg::MQF_W36);
    // One-block queue: fill to the brim, overfill, drain
    @(posedge i_clk);
    cfg_queue <= 4'h1;
    cfg_blocks <= 9'h001;
    cfg_ae <= 17'h00002;
    cfg_we <= 1'h1;
    rd_queue <= 4'h1;
    @(posedge i_clk);
    cfg_we <= 1'h0;
    for (int i = 1; i <= 256; i++) begin
      push(4'h1, 36'(i), took);
      if (i inside {2, 3, 239, 240, 255, 256}) settle();
      if (i == 2) flag(bus.almost_empty_flag_n, 1'h0);
      if (i == 3) flag(bus.almost_empty_flag_n, 1'h1);
      if (i == 239) flag(bus.almost_full_flag_n, 1'h1);
      if (i == 240) flag(bus.almost_full_flag_n, 1'h0);
      if (i == 255) flag(bus.full_flag_n, 1'h1);
      if (i == 256) flag(bus.full_flag_n, 1'h0);
    end
    push(4'h1, 36'h1FF, took);
    flag(took, 1'h0);
    for (int i = 1; i <= 256; i++) begin
      pop(4'h1, got);
      check(got, 36'(i));
    end
    settle();
    flag(bus.output_valid_n, 1'h1);
    // Only four queues in use: queue 6 refuses, queue 3 accepts
    set_glb(5'h04, mqf_pkg::MQF_W36, mqf_pkg::MQF_W36);
    @(posedge i_clk);
    rd_queue <= 4'h6;
    push(4'h6, 36'h66, took);
    flag(took, 1'h0);
    @(negedge i_clk);
    flag(bus.full_flag_n, 1'h0);
    flag(bus.output_valid_n, 1'h1);
    push(4'h3, 36'h33, took);
    flag(took, 1'h1);
    // A zero queue count and two narrow ports fall back to 16 queues, 36 both ways
    set_glb(5'h00, mqf_pkg::MQF_W9, mqf_pkg::MQF_W18);
    push(4'h6, 36'h987654321, took);
    flag(took, 1'h1);
    pop(4'h6, got);
    check(got, 36'h987654321);
    summarize();
  end

  // Hang guard, well beyond the expected run
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
